// *** inc/aifc_defs.vh ***
`ifndef AIFC_DEFS_VH
`define AIFC_DEFS_VH

// ****************************************
// register word indices, decoded from WB_ADR_I[7:2]
// ****************************************
`define AIFC_IDX_PWR2        6'h03
`define AIFC_IDX_FMT         6'h04
`define AIFC_IDX_STATUS      6'h08

// ****************************************
// reset values and write masks
// ****************************************
`define AIFC_PWR2_RESET      16'h0310
`define AIFC_FMT_RESET       16'h020a
`define AIFC_FMT_WMASK       16'hff7f

// ****************************************
// field positions in the format register
// ****************************************
`define AIFC_F_DIN_PULL      15:14
`define AIFC_F_LRC_PULL      13:12
`define AIFC_F_BCLK_PULL     11:10
`define AIFC_F_RSLOT_SEL     9
`define AIFC_F_LSLOT_SEL     8
`define AIFC_F_PLAY_SEL      6
`define AIFC_F_BIT_CLOCK_INVERT      5
`define AIFC_F_LRC_VARIANT   4
`define AIFC_F_WORD_LEN      3:2
`define AIFC_F_FORMAT        1:0

// ****************************************
// encodings
// ****************************************
`define AIFC_PULL_NONE       2'h0
`define AIFC_PULL_DOWN       2'h1
`define AIFC_PULL_UP         2'h2
`define AIFC_FMT_RSVD        2'h0
`define AIFC_FMT_LJ          2'h1
`define AIFC_FMT_I2S         2'h2
`define AIFC_FMT_DSP         2'h3
`define AIFC_WL_16           2'h0
`define AIFC_WL_20           2'h1
`define AIFC_WL_24           2'h2
`define AIFC_POS_MAX         7'h7f

`endif

// *** src/aifc_sync.v ***
`default_nettype none

// ****************************************
// two-stage synchroniser
// ****************************************
module aifc_sync (
  input  wire clk,
  input  wire rst,
  input  wire d,
  output reg  q
);

  reg meta_r;

  // first stage only feeds the second
  always @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // aifc_sync

`default_nettype wire

// *** src/aifc_pad_pull.v ***
`include "aifc_defs.vh"
`default_nettype none

// ****************************************
// pad pull decode for one pin
// ****************************************
module aifc_pad_pull (
  input  wire       clk,
  input  wire       rst,
  input  wire [1:0] code,
  output reg        pull_up,
  output reg        pull_down
);

  // reserved code drives neither pull
  always @(posedge clk) begin
    if (rst) begin
      pull_up   <= 1'b0;
      pull_down <= 1'b0;
    end else begin
      pull_up   <= (code == `AIFC_PULL_UP);
      pull_down <= (code == `AIFC_PULL_DOWN);
    end
  end

endmodule // aifc_pad_pull

`default_nettype wire

// *** src/aifc_top.v ***
// Implementation choice: the Wishbone interface to the registers.
`include "aifc_defs.vh"
`default_nettype none

module aifc_top (
  input  wire        CLOCK,
  input  wire        RESET,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [31:0] WB_DAT_I,
  input  wire [3:0]  WB_SEL_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        BIT_CLOCK,
  input  wire        FRAME_CLOCK,
  input  wire        PLAYBACK_SERIAL_IN,
  output reg         RECORD_SERIAL_OUT,
  input  wire [31:0] LEFT_ADC_SAMPLE,
  input  wire [31:0] RIGHT_ADC_SAMPLE,
  output reg  [31:0] PLAYBACK_SAMPLE,
  output reg         PLAYBACK_VALID,
  output wire        PLAYBACK_IN_PULL_UP,
  output wire        PLAYBACK_IN_PULL_DOWN,
  output wire        FRAME_CLOCK_PULL_UP,
  output wire        FRAME_CLOCK_PULL_DOWN,
  output wire        BIT_CLOCK_PULL_UP,
  output wire        BIT_CLOCK_PULL_DOWN,
  output wire [15:0] OUTPUT_POWER_CONTROL
);

  // ****************************************
  // register file
  // ****************************************
  reg  [15:0] pwr_r;
  reg  [15:0] fmt_r;
  reg  [31:0] rd_nxt;
  reg         seen_r;
  reg         ch_r;

  wire        wb_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire        wb_wr   = wb_req & WB_WE_I;
  wire [5:0]  wb_idx  = WB_ADR_I[7:2];
  wire [15:0] wr_mask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  wire [1:0]  frame_format_select          = fmt_r[`AIFC_F_FORMAT];
  wire [1:0]  sample_word_length           = fmt_r[`AIFC_F_WORD_LEN];
  wire        frame_polarity_or_dsp_variant = fmt_r[`AIFC_F_LRC_VARIANT];
  wire        bit_clock_invert             = fmt_r[`AIFC_F_BIT_CLOCK_INVERT];
  wire        playback_channel_select      = fmt_r[`AIFC_F_PLAY_SEL];
  wire        left_slot_record_select      = fmt_r[`AIFC_F_LSLOT_SEL];
  wire        right_slot_record_select     = fmt_r[`AIFC_F_RSLOT_SEL];
  wire        fmt_reserved                 = (frame_format_select == `AIFC_FMT_RSVD);

  assign OUTPUT_POWER_CONTROL = pwr_r;

  // register writes with byte lanes; ack one cycle after request
  always @(posedge CLOCK) begin
    if (RESET) begin
      pwr_r    <= `AIFC_PWR2_RESET;
      fmt_r    <= `AIFC_FMT_RESET;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req) begin
        WB_DAT_O <= rd_nxt;
      end
      if (wb_wr && wb_idx == `AIFC_IDX_PWR2) begin
        pwr_r <= (pwr_r & ~wr_mask) | (WB_DAT_I[15:0] & wr_mask);
      end
      if (wb_wr && wb_idx == `AIFC_IDX_FMT) begin
        fmt_r <= (fmt_r & ~(wr_mask & `AIFC_FMT_WMASK)) | (WB_DAT_I[15:0] & wr_mask & `AIFC_FMT_WMASK);
      end
    end
  end

  // read mux, unmapped reads return zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (wb_idx)
      `AIFC_IDX_PWR2:   rd_nxt = {16'h0000, pwr_r};
      `AIFC_IDX_FMT:    rd_nxt = {16'h0000, fmt_r};
      `AIFC_IDX_STATUS: rd_nxt = {29'h0000_0000, ch_r, fmt_reserved, seen_r};
      default:          rd_nxt = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // pad pulls
  // ****************************************
  // playback input pull
  aifc_pad_pull u_pull_din (
    .clk       (CLOCK),
    .rst       (RESET),
    .code      (fmt_r[`AIFC_F_DIN_PULL]),
    .pull_up   (PLAYBACK_IN_PULL_UP),
    .pull_down (PLAYBACK_IN_PULL_DOWN)
  );

  aifc_pad_pull u_pull_lrc (
    .clk       (CLOCK),
    .rst       (RESET),
    .code      (fmt_r[`AIFC_F_LRC_PULL]),
    .pull_up   (FRAME_CLOCK_PULL_UP),
    .pull_down (FRAME_CLOCK_PULL_DOWN)
  );

  aifc_pad_pull u_pull_bclk (
    .clk       (CLOCK),
    .rst       (RESET),
    .code      (fmt_r[`AIFC_F_BCLK_PULL]),
    .pull_up   (BIT_CLOCK_PULL_UP),
    .pull_down (BIT_CLOCK_PULL_DOWN)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire bclk_s;
  wire lrc_s;
  wire din_s;

  aifc_sync u_sync_bclk (
    .clk (CLOCK),
    .rst (RESET),
    .d   (BIT_CLOCK),
    .q   (bclk_s)
  );

  aifc_sync u_sync_lrc (
    .clk (CLOCK),
    .rst (RESET),
    .d   (FRAME_CLOCK),
    .q   (lrc_s)
  );

  aifc_sync u_sync_din (
    .clk (CLOCK),
    .rst (RESET),
    .d   (PLAYBACK_SERIAL_IN),
    .q   (din_s)
  );

  // ****************************************
  // bit clock edges and frame decode
  // ****************************************
  reg        bclk_d_r;
  reg        lrc_prev_r;
  reg  [6:0] pos_r;
  reg  [31:0] rx_shift_r;
  reg  [31:0] tx_left_r;
  reg  [31:0] tx_right_r;
  reg  [5:0] wl_bits;

  // pin edges as seen after the synchroniser
  // both edges lag the pin by about two clocks
  wire raw_rise = bclk_s & ~bclk_d_r;
  wire raw_fall = ~bclk_s & bclk_d_r;
  wire samp_edge   = bit_clock_invert ? raw_fall : raw_rise;
  wire launch_edge = bit_clock_invert ? raw_rise : raw_fall;

  wire is_dsp = (frame_format_select == `AIFC_FMT_DSP);
  wire is_lj  = (frame_format_select == `AIFC_FMT_LJ);
  wire is_i2s = (frame_format_select == `AIFC_FMT_I2S);

  // frame start: dsp rise, others any change
  wire start = is_dsp ? (lrc_s & ~lrc_prev_r) : (lrc_s ^ lrc_prev_r);

  // polarity flip picks right slot level
  wire right_lvl = lrc_s ^ frame_polarity_or_dsp_variant ^ is_lj;

  // mode A and I2S delay one edge
  // mode B and left-justified delay none
  wire [6:0] delay = is_dsp ? {6'h00, ~frame_polarity_or_dsp_variant} : {6'h00, is_i2s};

  // word length decode
  // code 11 falls to the default, 32 bits
  always @* begin
    case (sample_word_length)
      `AIFC_WL_16: wl_bits = 6'h10;
      `AIFC_WL_20: wl_bits = 6'h14;
      `AIFC_WL_24: wl_bits = 6'h18;
      default:     wl_bits = 6'h20;
    endcase
  end

  // position of the coming sampling edge within the frame
  wire [6:0] pos_up  = start ? 7'h00 : ((pos_r == `AIFC_POS_MAX) ? pos_r : pos_r + 7'h01);
  wire [6:0] wl7     = {1'b0, wl_bits};
  wire [6:0] bidx    = pos_up - delay;
  wire       idx_ok  = (pos_up >= delay) & ~fmt_reserved & (seen_r | start);
  wire       chan    = is_dsp ? (bidx >= wl7) : (start ? right_lvl : ch_r);
  wire [6:0] cidx    = (is_dsp && chan) ? bidx - wl7 : bidx;
  wire       in_slot = idx_ok & (is_dsp ? (bidx < {wl7[5:0], 1'b0}) : (bidx < wl7));
  wire       last    = in_slot & (cidx == wl7 - 7'h01);

  // ****************************************
  // playback receive
  // ****************************************
  wire [31:0] rx_word = {rx_shift_r[30:0], din_s};
  // left shift puts the msb at bit 31
  wire [5:0]  shamt   = 6'h20 - wl_bits;

  // sample on the active edge, deliver selected slot
  always @(posedge CLOCK) begin
    if (RESET) begin
      bclk_d_r        <= 1'b0;
      lrc_prev_r      <= 1'b0;
      pos_r           <= `AIFC_POS_MAX;
      ch_r            <= 1'b0;
      seen_r          <= 1'b0;
      rx_shift_r      <= 32'h0000_0000;
      PLAYBACK_SAMPLE <= 32'h0000_0000;
      PLAYBACK_VALID  <= 1'b0;
    end else begin
      bclk_d_r       <= bclk_s;
      PLAYBACK_VALID <= 1'b0;
      if (samp_edge) begin
        lrc_prev_r <= lrc_s;
        pos_r      <= pos_up;
        if (start) begin
          ch_r <= right_lvl;
        end
        if (start && !fmt_reserved) begin
          seen_r <= 1'b1;
        end
        if (in_slot) begin
          rx_shift_r <= rx_word;
        end
        // only the selected slot reaches the dac path
        if (last && chan == playback_channel_select) begin
          PLAYBACK_SAMPLE <= rx_word << shamt;
          PLAYBACK_VALID  <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // record transmit
  // ****************************************
  // left slot source
  wire [31:0] left_src  = left_slot_record_select ? RIGHT_ADC_SAMPLE : LEFT_ADC_SAMPLE;
  wire [31:0] right_src = right_slot_record_select ? RIGHT_ADC_SAMPLE : LEFT_ADC_SAMPLE;

  wire [31:0] tx_l    = start ? left_src : tx_left_r;
  wire [31:0] tx_r    = start ? right_src : tx_right_r;
  wire [31:0] tx_word = chan ? tx_r : tx_l;
  // samples are latched at the frame start launch edge
  // so a mid-frame adc change cannot tear a word
  wire [4:0]  tx_bit  = 5'h1f - cidx[4:0];

  // launch bit on the opposite edge, zero outside the slot
  always @(posedge CLOCK) begin
    if (RESET) begin
      tx_left_r         <= 32'h0000_0000;
      tx_right_r        <= 32'h0000_0000;
      RECORD_SERIAL_OUT <= 1'b0;
    end else if (launch_edge) begin
      if (start) begin
        tx_left_r  <= left_src;
        tx_right_r <= right_src;
      end
      // msb ready before the first sampled slot edge
      RECORD_SERIAL_OUT <= in_slot ? tx_word[tx_bit] : 1'b0;
    end
  end

endmodule // aifc_top

`default_nettype wire

// *** tb/aifc_chk_asserts.sv ***
`default_nettype none
// ************
// bus and pull checks
// ************
module aifc_chk (
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        PLAYBACK_IN_PULL_UP,
  input wire logic        PLAYBACK_IN_PULL_DOWN,
  input wire logic        FRAME_CLOCK_PULL_UP,
  input wire logic        FRAME_CLOCK_PULL_DOWN,
  input wire logic        BIT_CLOCK_PULL_UP,
  input wire logic        BIT_CLOCK_PULL_DOWN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       req;
  logic       rd;
  logic       fw;
  logic [5:0] code_r;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // request decode
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign rd  = req && !WB_WE_I;
  assign fw  = req && WB_WE_I && WB_ADR_I[7:2] == 6'h04;
  // pull codes of the last format write
  always_ff @(posedge CLOCK) code_r <= fw ? WB_DAT_I[15:10] : code_r;
  sequence s_fw;
    fw ##3 1'b1;
  endsequence
  property p_pull(up, dn, c);
    s_fw |-> up == (c == 2'h2) && dn == (c == 2'h1);
  endproperty
  din_pull_a: assert property (p_pull(PLAYBACK_IN_PULL_UP, PLAYBACK_IN_PULL_DOWN, code_r[5:4]))
    else $error("input pull");
  frame_pull_a: assert property (p_pull(FRAME_CLOCK_PULL_UP, FRAME_CLOCK_PULL_DOWN, code_r[3:2]))
    else $error("frame pull");
  bclk_pull_a: assert property (p_pull(BIT_CLOCK_PULL_UP, BIT_CLOCK_PULL_DOWN, code_r[1:0]))
    else $error("bit clock pull");
  ack_next_a: assert property (req |=> WB_ACK_O)
    else $error("ack missing");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  ack_cause_a: assert property (WB_ACK_O |-> $past(req))
    else $error("stray ack");
  unmapped_read_a: assert property (rd && WB_ADR_I[7:2] == 6'h0f |=> WB_DAT_O == 32'h0)
    else $error("unmapped read");
  fmt_read_a: assert property (rd && WB_ADR_I[7:2] == 6'h04 |=> WB_DAT_O[31:16] == 16'h0 && !WB_DAT_O[7])
    else $error("reserved bits");
endmodule // aifc_chk

bind aifc_top aifc_chk chk_u (.CLOCK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_I, .WB_DAT_O,
  .WB_ACK_O, .PLAYBACK_IN_PULL_UP, .PLAYBACK_IN_PULL_DOWN, .FRAME_CLOCK_PULL_UP, .FRAME_CLOCK_PULL_DOWN,
  .BIT_CLOCK_PULL_UP, .BIT_CLOCK_PULL_DOWN);
`default_nettype wire

// *** tb/aifc_host.sv ***
`default_nettype none
// ************
// host serial port
// ************
module aifc_host (
  output var logic bclk,
  output var logic frame,
  output var logic dout,
  input  wire logic din
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock stands still until a frame
  initial begin
    bclk = 1'b0;
    frame = 1'b0;
    dout = 1'b0;
  end
  // one frame, 80 ns per bit, priming edge first
  task automatic xfer(input logic [15:0] cfg, input int wl, input logic [31:0] l, r,
                      output logic [31:0] rl, rr);
    int d, s, e, p;
    d = (cfg[1:0] == 2'h1 || cfg[1:0] == 2'h3 && cfg[4]) ? 0 : 1;
    s = wl + 2;
    rl = 32'h0;
    rr = 32'h0;
    #2;
    for (e = -1; e < 2 * s; e++) begin
      p = (e >= 0 && e % s >= d && e % s - d < wl) ? e / s * wl + e % s - d : -1;
      if (cfg[1:0] == 2'h3) p = e - d;
      bclk = cfg[5];
      frame = cfg[1:0] == 2'h3 ? e == 0 : (e >= 0 && e < s) ^ (cfg[1:0] == 2'h2) ^ cfg[4];
      dout = (p >= 0 && p < 2 * wl) ? (p < wl ? l[31 - p] : r[31 - p + wl]) : ~dout;
      #40;
      bclk = ~cfg[5];
      if (p >= 0 && p < wl) rl[31 - p] = din;
      if (p >= wl && p < 2 * wl) rr[31 - p + wl] = din;
      #40;
    end
  endtask
endmodule // aifc_host
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
// ************
// config and link bench
// ************
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] adc_l = 32'hc3a59e17;
  localparam logic [31:0] adc_r = 32'h5b1e74d9;
  logic        clock = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pb_v, bclk, frame, pin, rec;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wdat = 32'h0, dat_o, rd, pb, pb_last;
  logic [15:0] pwr;
  wire  [5:0]  pulls;
  int          n_mismatch, tests_run, cycles;
  aifc_top dut_u (.CLOCK(clock), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(4'h3), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .BIT_CLOCK(bclk), .FRAME_CLOCK(frame), .PLAYBACK_SERIAL_IN(pin), .RECORD_SERIAL_OUT(rec),
    .LEFT_ADC_SAMPLE(adc_l), .RIGHT_ADC_SAMPLE(adc_r), .PLAYBACK_SAMPLE(pb), .PLAYBACK_VALID(pb_v),
    .PLAYBACK_IN_PULL_UP(pulls[5]), .PLAYBACK_IN_PULL_DOWN(pulls[4]), .FRAME_CLOCK_PULL_UP(pulls[3]),
    .FRAME_CLOCK_PULL_DOWN(pulls[2]), .BIT_CLOCK_PULL_UP(pulls[1]), .BIT_CLOCK_PULL_DOWN(pulls[0]),
    .OUTPUT_POWER_CONTROL(pwr));
  aifc_host host_u (.bclk(bclk), .frame(frame), .dout(pin), .din(rec));
  // bench clock
  initial begin
    forever #4 clock = ~clock;
  end
  // hang guard and playback capture
  always @(posedge clock) begin
    cycles++;
    if (pb_v === 1'b1) pb_last <= pb;
    if (cycles == 30000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clock); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // reset values, access kinds, unmapped word
  task automatic test_regs();
    check(pulls, 0);
    check(pwr, 16'h0310);
    wb(0, 8'h10, 0);
    check(rd[15:10], 0);
    check(rd[9:8], 2'h2);
    check(rd[6:4], 0);
    check(rd[3:0], 4'ha);
    wb(1, 8'h0c, 32'h5aa5);
    check(pwr, 16'h5aa5);
    wb(1, 8'h3c, 32'hffff);
    wb(0, 8'h3c, 0);
    check(rd, 0);
    wb(1, 8'h10, 32'hffffffff);
    wb(0, 8'h10, 0);
    check(rd, 32'hff7f);
    wb(1, 8'h10, 32'h0200);
    wb(0, 8'h20, 0);
    check(rd[1], 1'b1);
  endtask
  // every pull code on all three pins
  task automatic test_pulls();
    for (int k = 0; k < 4; k++) begin
      wb(1, 8'h10, {16'h0, {3{k[1:0]}}, 10'h20a});
      wb(0, 8'h10, 0);
      check(pulls, {3{k == 2, k == 1}});
    end
  endtask
  // two frames; the second is judged
  task automatic test_link(input logic [15:0] cfg, input int wl);
    logic [31:0] rl, rr, m, l, r;
    m = 32'hffffffff << (32 - wl);
    l = 32'h8d312b6e;
    r = 32'h71f0a4c5;
    wb(1, 8'h10, {16'h0, cfg});
    repeat (2) host_u.xfer(cfg, wl, l, r, rl, rr);
    check(rl, (cfg[8] ? adc_r : adc_l) & m);
    check(rr, (cfg[9] ? adc_r : adc_l) & m);
    check(pb_last, (cfg[6] ? r : l) & m);
    wb(0, 8'h20, 0);
    check(rd[1:0], 2'h1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    test_regs();
    test_pulls();
    test_link(16'h0202, 16);
    test_link(16'h0175, 20);
    test_link(16'h034b, 24);
    test_link(16'h003f, 32);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
